// file: core/rsv_pkg.sv
// constants for the regulator status, identity and preset register bank
// assumes a byte-wide register access port driven by a serial bus engine

package rsv_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] RSV_ADDR_CTRL  = 8'h01;
    localparam logic [7:0] RSV_ADDR_FAULT = 8'h02;
    localparam logic [7:0] RSV_ADDR_ID    = 8'h03;
    localparam logic [7:0] RSV_ADDR_PLOW  = 8'h04;
    localparam logic [7:0] RSV_ADDR_PHIGH = 8'h05;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int RSV_FAULT_NG_BIT   = 0;
    localparam int RSV_FAULT_OT_BIT   = 1;
    localparam int RSV_CTRL_RANGE_BIT = 6;
    localparam int RSV_ID_MAKER_LSB   = 4;
    localparam int RSV_ID_MAJOR_LSB   = 2;
    localparam int RSV_ID_MINOR_LSB   = 0;

    // ------------------------------------------------------------------
    // values after reset, and the value read from unmapped offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] RSV_FAULT_RST = 8'h00;
    localparam logic [7:0] RSV_CTRL_RST  = 8'h00;
    localparam logic [6:0] RSV_PLOW_RST  = 7'h3c;
    localparam logic [6:0] RSV_PHIGH_RST = 7'h42;
    localparam logic [7:0] RSV_RD_UNMAP  = 8'h00;

    // ------------------------------------------------------------------
    // target voltage arithmetic, millivolts
    // ------------------------------------------------------------------
    localparam logic [12:0] RSV_BASE_LOW_MV  = 13'h708;
    localparam logic [12:0] RSV_BASE_HIGH_MV = 13'h7e9;
    localparam logic [12:0] RSV_STEP_MV      = 13'h019;

endpackage : rsv_pkg

// file: core/rsv_sticky_flag.sv
// one sticky fault flag that clears on read once its condition is gone
// assumes the condition input is synchronous to clock

`timescale 1ns/1ps

module rsv_sticky_flag
    import rsv_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic cond,
    input  wire logic rd_clr,
    output logic      flag_r
);

    // ------------------------------------------------------------------
    // flag storage
    // ------------------------------------------------------------------
    logic flag_nxt;

    // a live condition always wins over the read clear, so no event is lost
    always_comb
    begin
        flag_nxt = flag_r;
        if (rd_clr)
        begin
            flag_nxt = 1'b0;
        end
        if (cond)
        begin
            flag_nxt = 1'b1;
        end
    end

    // reset to zero, update every cycle
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            flag_r <= 1'b0;
        end
        else
        begin
            flag_r <= flag_nxt;
        end
    end

endmodule : rsv_sticky_flag

// file: core/rsv_reg_bank.sv
// register bank: fault flags, identity, two voltage presets, range bit
// assumes a bus engine hands over decoded byte reads and committed writes

`timescale 1ns/1ps

module rsv_reg_bank
    import rsv_pkg::*;
#(
    parameter logic [3:0] MAKER_CODE = 4'h9,  // arbitrary value
    parameter logic [1:0] MAJOR_REV  = 2'h1,  // arbitrary value
    parameter logic [1:0] MINOR_REV  = 2'h2   // arbitrary value
)
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  acc_addr,
    input  wire logic [7:0]  acc_wdata,
    input  wire logic        acc_wr,
    input  wire logic        acc_rd,
    output logic      [7:0]  acc_rdata,
    input  wire logic        overtemp_cond,
    input  wire logic        power_not_good_cond,
    input  wire logic        preset_select_pin,
    output logic      [7:0]  control_out,
    output logic             range_high,
    output logic      [6:0]  active_code,
    output logic      [12:0] target_mv,
    output logic             overtemp_flag,
    output logic             output_not_good_flag
);

    // ------------------------------------------------------------------
    // storage and decode
    // ------------------------------------------------------------------
    logic [7:0]  control_r;
    logic [6:0]  preset_low_code_r;
    logic [6:0]  preset_high_code_r;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;
    logic [6:0]  code_r;
    logic [12:0] target_r;
    logic [12:0] target_nxt;
    logic [7:0]  fault_view;
    logic [7:0]  id_view;
    logic        fault_rd;
    logic        ot_clr;
    logic        ng_clr;
    logic        ot_flag;
    logic        ng_flag;

    // apart from reset, a read of the fault register is the only thing that clears flags
    assign fault_rd = acc_rd && (acc_addr == RSV_ADDR_FAULT);
    assign ot_clr   = fault_rd && !overtemp_cond;
    assign ng_clr   = fault_rd && !power_not_good_cond;

    // ------------------------------------------------------------------
    // sticky fault flags
    // ------------------------------------------------------------------
    // overtemperature flag, bit 1
    rsv_sticky_flag u_ot_flag
    (
        .clock  (clock),
        .rst    (rst),
        .cond   (overtemp_cond),
        .rd_clr (ot_clr),
        .flag_r (ot_flag)
    );

    // output-not-good flag, bit 0
    rsv_sticky_flag u_ng_flag
    (
        .clock  (clock),
        .rst    (rst),
        .cond   (power_not_good_cond),
        .rd_clr (ng_clr),
        .flag_r (ng_flag)
    );

    // ------------------------------------------------------------------
    // read views
    // ------------------------------------------------------------------
    // fault byte: upper six bits are hardwired zero
    always_comb
    begin
        fault_view                   = RSV_FAULT_RST;
        fault_view[RSV_FAULT_OT_BIT] = ot_flag;
        fault_view[RSV_FAULT_NG_BIT] = ng_flag;
    end

    // identity byte is built from constants, nothing can write it
    always_comb
    begin
        id_view                                         = 8'h00;
        id_view[RSV_ID_MAKER_LSB +: 4]                  = MAKER_CODE;
        id_view[RSV_ID_MAJOR_LSB +: 2]                  = MAJOR_REV;
        id_view[RSV_ID_MINOR_LSB +: 2]                  = MINOR_REV;
    end

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    // whole byte is kept so software reads back what it wrote
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            control_r <= RSV_CTRL_RST;
        end
        else if (acc_wr && (acc_addr == RSV_ADDR_CTRL))
        begin
            control_r <= acc_wdata;
        end
    end

    // ------------------------------------------------------------------
    // preset registers
    // ------------------------------------------------------------------
    // low preset; bit 7 of the write data is dropped, not stored
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            preset_low_code_r <= RSV_PLOW_RST;
        end
        else if (acc_wr && (acc_addr == RSV_ADDR_PLOW))
        begin
            preset_low_code_r <= acc_wdata[6:0];
        end
    end

    // high preset; same shape as the low one
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            preset_high_code_r <= RSV_PHIGH_RST;
        end
        else if (acc_wr && (acc_addr == RSV_ADDR_PHIGH))
        begin
            preset_high_code_r <= acc_wdata[6:0];
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    // fault and identity writes fall through here with no storage
    always_comb
    begin
        unique case (acc_addr)
            RSV_ADDR_CTRL:  rdata_nxt = control_r;
            RSV_ADDR_FAULT: rdata_nxt = fault_view;
            RSV_ADDR_ID:    rdata_nxt = id_view;
            RSV_ADDR_PLOW:  rdata_nxt = {1'b0, preset_low_code_r};
            RSV_ADDR_PHIGH: rdata_nxt = {1'b0, preset_high_code_r};
            default:        rdata_nxt = RSV_RD_UNMAP;
        endcase
    end

    // the fault byte is captured before the clear lands, so a read
    // reports the event it is acknowledging
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rdata_r <= 8'h00;
        end
        else if (acc_rd)
        begin
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // active code and target voltage
    // ------------------------------------------------------------------
    // pin picks the preset, control bit 6 picks the base
    always_comb
    begin
        if (control_r[RSV_CTRL_RANGE_BIT])
        begin
            target_nxt = RSV_BASE_HIGH_MV;
        end
        else
        begin
            target_nxt = RSV_BASE_LOW_MV;
        end
        target_nxt = target_nxt + 13'(code_r * RSV_STEP_MV);
    end

    // code follows the pin one cycle later; target one cycle after that
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            code_r   <= RSV_PLOW_RST;
            target_r <= 13'(RSV_BASE_LOW_MV + 13'(RSV_PLOW_RST * RSV_STEP_MV));
        end
        else
        begin
            code_r   <= preset_select_pin ? preset_high_code_r
                                          : preset_low_code_r;
            target_r <= target_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign acc_rdata            = rdata_r;
    assign control_out          = control_r;
    assign range_high           = control_r[RSV_CTRL_RANGE_BIT];
    assign active_code          = code_r;
    assign target_mv            = target_r;
    assign overtemp_flag        = ot_flag;
    assign output_not_good_flag = ng_flag;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    fault_upper_zero_a: assert property (
        @(posedge clock) disable iff (rst)
        $past(acc_rd) && ($past(acc_addr) == RSV_ADDR_FAULT)
            |-> (acc_rdata[7:2] == 6'h00))
        else $error("fault register upper bits not zero");

    // reset is looked at from the edge that applies it, so the very first
    // clock tick needs no history
    fault_reset_a: assert property (
        @(posedge clock)
        rst |=> (!ot_flag && !ng_flag && (control_r == RSV_CTRL_RST)))
        else $error("flags not cleared by reset");

    overtemp_set_a: assert property (
        @(posedge clock) disable iff (rst)
        overtemp_cond |=> ot_flag)
        else $error("overtemp event did not set flag");

    overtemp_clear_a: assert property (
        @(posedge clock) disable iff (rst)
        fault_rd && ot_flag && !overtemp_cond
            |=> !ot_flag && acc_rdata[RSV_FAULT_OT_BIT])
        else $error("overtemp flag read-clear wrong");

    overtemp_hold_a: assert property (
        @(posedge clock) disable iff (rst)
        ot_flag && !(fault_rd && !overtemp_cond) |=> ot_flag)
        else $error("overtemp flag dropped without a clearing read");

    notgood_set_a: assert property (
        @(posedge clock) disable iff (rst)
        power_not_good_cond |=> ng_flag [*1] ##0 fault_view[RSV_FAULT_NG_BIT])
        else $error("not-good event did not set flag");

    notgood_clear_a: assert property (
        @(posedge clock) disable iff (rst)
        fault_rd && !power_not_good_cond
            |=> !ng_flag)
        else $error("not-good flag not cleared by read");

    identity_read_a: assert property (
        @(posedge clock) disable iff (rst)
        acc_rd && (acc_addr == RSV_ADDR_ID)
            |=> (acc_rdata == {MAKER_CODE, MAJOR_REV, MINOR_REV}))
        else $error("identity read mismatch");

    preset_low_wr_a: assert property (
        @(posedge clock) disable iff (rst)
        acc_wr && (acc_addr == RSV_ADDR_PLOW)
            |=> (preset_low_code_r == $past(acc_wdata[6:0])))
        else $error("low preset write not taken");

    preset_high_wr_a: assert property (
        @(posedge clock) disable iff (rst)
        acc_wr && (acc_addr == RSV_ADDR_PHIGH)
            |=> (preset_high_code_r == $past(acc_wdata[6:0])))
        else $error("high preset write not taken");

    target_low_a: assert property (
        @(posedge clock) disable iff (rst)
        !range_high && $stable(range_high) && !$past(rst)
            |=> (target_mv == 13'(RSV_BASE_LOW_MV + 13'($past(code_r) * RSV_STEP_MV))))
        else $error("low range target wrong");

    target_high_a: assert property (
        @(posedge clock) disable iff (rst)
        range_high && $stable(range_high) && !$past(rst)
            |=> (target_mv == 13'(RSV_BASE_HIGH_MV + 13'($past(code_r) * RSV_STEP_MV))))
        else $error("high range target wrong");

    preset_reset_a: assert property (
        @(posedge clock)
        rst |=> (preset_low_code_r == RSV_PLOW_RST)
                && (preset_high_code_r == RSV_PHIGH_RST))
        else $error("presets not at reset values");

    preset_top_zero_a: assert property (
        @(posedge clock) disable iff (rst)
        $past(acc_rd) && (($past(acc_addr) == RSV_ADDR_PLOW)
                          || ($past(acc_addr) == RSV_ADDR_PHIGH))
            |-> !acc_rdata[7])
        else $error("preset bit 7 not zero");

    code_select_a: assert property (
        @(posedge clock) disable iff (rst)
        preset_select_pin ##1 $stable(preset_high_code_r)
            |-> (active_code == preset_high_code_r))
        else $error("active code ignores select pin");

    code_low_a: assert property (
        @(posedge clock) disable iff (rst)
        !preset_select_pin ##1 $stable(preset_low_code_r)
            |-> (active_code == preset_low_code_r))
        else $error("active code ignores low preset");

    unmapped_zero_a: assert property (
        @(posedge clock) disable iff (rst)
        acc_rd && ((acc_addr == 8'h00) || (acc_addr > RSV_ADDR_PHIGH))
            |=> (acc_rdata == RSV_RD_UNMAP))
        else $error("unmapped read not zero");

    ro_write_a: assert property (
        @(posedge clock) disable iff (rst)
        acc_wr && !acc_rd && !overtemp_cond && !power_not_good_cond
            && ((acc_addr == RSV_ADDR_FAULT) || (acc_addr == RSV_ADDR_ID))
            |=> $stable(fault_view) && $stable(control_r)
                && $stable(preset_low_code_r) && $stable(preset_high_code_r))
        else $error("write to read-only register changed state");

endmodule : rsv_reg_bank

// file: dv/rsv_host_model.sv
// bus controller model: hands the register bank single-byte reads and writes
// assumes the shared 125 MHz clock; lines move 1 ns after the rising edge

`timescale 1ns/1ps

module rsv_host_model
(
    input  wire logic       clock,
    output logic      [7:0] acc_addr,
    output logic      [7:0] acc_wdata,
    output logic            acc_wr,
    output logic            acc_rd,
    input  wire logic [7:0] acc_rdata
);
    // ------------------------------------------------------------------
    // idle lines and byte transfers
    // ------------------------------------------------------------------
    // strobes idle low; released lines show the inverse of their last value
    initial
    begin
        acc_addr  = 8'h00;
        acc_wdata = 8'h00;
        acc_wr    = 1'b0;
        acc_rd    = 1'b0;
    end

    // one committed byte, as the engine pulses it at the ack falling edge
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock);
        #1;
        acc_addr  = addr;
        acc_wdata = data;
        acc_wr    = 1'b1;
        @(posedge clock);
        #1;
        acc_wr    = 1'b0;
        acc_addr  = ~addr;
        acc_wdata = ~data;
    endtask : write_reg

    // one fetched byte; data is taken once the taking edge has landed
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clock);
        #1;
        acc_addr = addr;
        acc_rd   = 1'b1;
        @(posedge clock);
        #1;
        data     = acc_rdata;
        acc_rd   = 1'b0;
        acc_addr = ~addr;
    endtask : read_reg
endmodule : rsv_host_model

// file: dv/rsv_reg_bank_tb.sv
// self-checking bench for the regulator register bank
// assumes the bus controller model drives the register port

`timescale 1ns/1ps

module rsv_reg_bank_tb;
    import rsv_pkg::*;

    logic        clock = 1'b0;
    logic        rst   = 1'b1;
    logic [7:0]  acc_addr;
    logic [7:0]  acc_wdata;
    logic        acc_wr;
    logic        acc_rd;
    logic [7:0]  acc_rdata;
    logic        ot_cond = 1'b0;
    logic        ng_cond = 1'b0;
    logic        sel_pin = 1'b0;
    logic [7:0]  control_out;
    logic        range_high;
    logic [6:0]  active_code;
    logic [12:0] target_mv;
    logic        ot_flag;
    logic        ng_flag;
    int          fail_count = 0;
    int          checked    = 0;
    logic [31:0] lfsr       = 32'h8a79ca9e;
    logic [7:0]  rd;
    logic [6:0]  plow;
    logic [6:0]  phigh;
    logic [7:0]  holes [4] = '{8'h00, 8'h06, 8'h7f, 8'hff};

    always #4 clock = ~clock;

    rsv_reg_bank u_dut (.clock(clock), .rst(rst), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_rdata(acc_rdata), .overtemp_cond(ot_cond),
        .power_not_good_cond(ng_cond), .preset_select_pin(sel_pin), .control_out(control_out),
        .range_high(range_high), .active_code(active_code), .target_mv(target_mv),
        .overtemp_flag(ot_flag), .output_not_good_flag(ng_flag));

    rsv_host_model u_host (.clock(clock), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_rdata(acc_rdata));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // taps 32,22,2,1 give a maximal-length sequence
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next

    // expected millivolts from range and active code
    function automatic logic [12:0] exp_mv(input logic hi, input logic [6:0] code);
        return (hi ? 13'd2025 : 13'd1800) + 13'(code) * 13'd25;
    endfunction : exp_mv

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
        u_host.read_reg(addr, rd);
        check($sformatf("reg %h", addr), {8'h00, exp}, {8'h00, rd});
    endtask : rd_check

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clock);
        #1;
        rst = 1'b0;
        // values after reset, identity byte and unmapped holes
        rd_check(RSV_ADDR_FAULT, 8'h00);
        rd_check(RSV_ADDR_PLOW, 8'h3c);
        rd_check(RSV_ADDR_PHIGH, 8'h42);
        rd_check(RSV_ADDR_ID, 8'h96);
        rd_check(RSV_ADDR_CTRL, 8'h00);
        check("target", 16'd3300, {3'h0, target_mv});
        foreach (holes[i])
            rd_check(holes[i], 8'h00);
        // writes to the read-only places are swallowed
        u_host.write_reg(RSV_ADDR_ID, 8'h5a);
        u_host.write_reg(RSV_ADDR_FAULT, 8'hff);
        u_host.write_reg(8'h06, 8'hff);
        rd_check(RSV_ADDR_ID, 8'h96);
        rd_check(RSV_ADDR_FAULT, 8'h00);
        rd_check(8'h06, 8'h00);
        // random presets, bit 7 set at random, random pin and range
        for (int n = 0; n < 40; n++)
        begin
            lfsr = lfsr_next(lfsr);
            plow  = (n == 0) ? 7'h00 : (n == 1) ? 7'h7f : lfsr[6:0];
            phigh = (n == 0) ? 7'h7f : (n == 1) ? 7'h00 : lfsr[14:8];
            u_host.write_reg(RSV_ADDR_PLOW, {lfsr[7], plow});
            u_host.write_reg(RSV_ADDR_PHIGH, {lfsr[15], phigh});
            u_host.write_reg(RSV_ADDR_CTRL, {lfsr[16], lfsr[17], 6'h00});
            sel_pin = lfsr[18];
            rd_check(RSV_ADDR_PLOW, {1'b0, plow});
            rd_check(RSV_ADDR_PHIGH, {1'b0, phigh});
            repeat (3) @(posedge clock);
            #1;
            check("range", {15'h0, lfsr[17]}, {15'h0, range_high});
            check("control", {8'h00, lfsr[16], lfsr[17], 6'h00}, {8'h00, control_out});
            check("code", {9'h0, lfsr[18] ? phigh : plow}, {9'h0, active_code});
            check("target", {3'h0, exp_mv(lfsr[17], lfsr[18] ? phigh : plow)}, {3'h0, target_mv});
        end
        // sticky flags: a read while the condition lasts leaves them set
        ot_cond = 1'b1;
        ng_cond = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        ot_cond = 1'b0;
        ng_cond = 1'b0;
        @(posedge clock);
        #1;
        check("flags", 16'h0003, {14'h0, ot_flag, ng_flag});
        ot_cond = 1'b1;
        ng_cond = 1'b1;
        rd_check(RSV_ADDR_FAULT, 8'h03);
        ot_cond = 1'b0;
        rd_check(RSV_ADDR_FAULT, 8'h03);
        rd_check(RSV_ADDR_FAULT, 8'h01);
        ng_cond = 1'b0;
        rd_check(RSV_ADDR_FAULT, 8'h01);
        rd_check(RSV_ADDR_FAULT, 8'h00);
        check("flags", 16'h0000, {14'h0, ot_flag, ng_flag});
        // mid-run reset with a flag set and both presets rewritten
        ot_cond = 1'b1;
        sel_pin = 1'b0;
        @(posedge clock);
        #1;
        ot_cond = 1'b0;
        rst     = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        rst = 1'b0;
        rd_check(RSV_ADDR_FAULT, 8'h00);
        rd_check(RSV_ADDR_PLOW, 8'h3c);
        rd_check(RSV_ADDR_PHIGH, 8'h42);
        rd_check(RSV_ADDR_CTRL, 8'h00);
        check("target", 16'd3300, {3'h0, target_mv});
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // watchdog, far beyond the fewer than six hundred cycles the run needs
    // ------------------------------------------------------------------
    initial
    begin
        #200000;
        fail_count++;
        report_and_stop();
    end
endmodule : rsv_reg_bank_tb
